// [design/osc_source_ctrl.sv]
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "osc_regs.svh"

module osc_source_ctrl
  import osc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Nonvolatile option and factory trim
  input wire logic crystal_off_option,
  input wire logic [7:0] factory_trim,
  // Crystal clock as seen at the pin
  input wire logic xtal_clk_pin,
  // Oscillator controls
  output logic crystal_enable_bit,
  output logic crystal_pin_override,
  output logic internal_osc_enable_bit,
  output logic fast_slow_select,
  output logic [7:0] ipo_trim,
  output logic [2:0] system_clock_source_select,
  output logic [4:0] ctrl_misc
);

  localparam osc_state_t RST_STATE = '{
    init: OSC_INIT_SYNC,
    lock: OSC_LOCKED,
    ctrl: `OSC_CTRL_RST,
    ipo_fast: 1'b1,
    off_s: 2'h0,
    trim_s0: 8'h00,
    trim_s1: 8'h00,
    xsync: 3'h0,
    xcnt: 10'h000,
    xstable: 1'b0,
    aw_held: 1'b0,
    aw_addr: 8'h00,
    w_held: 1'b0,
    wdata: 8'h00,
    wstb: 1'b0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: `OSC_RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: `OSC_RESP_OKAY
  };

  osc_state_t r_r;
  osc_state_t r_nxt;
  logic trim_load;
  logic trim_wr;
  logic [7:0] trim_q;
  logic user_trim_q;

  function automatic osc_reg_t osc_decode(input logic [7:0] addr);
    if (addr == `OSC_CTRL_OFS) begin
      return OSC_REG_CTRL;
    end else if (addr == `OSC_UNLOCK_OFS) begin
      return OSC_REG_UNLOCK;
    end else if (addr == `OSC_TRIM_OFS) begin
      return OSC_REG_TRIM;
    end else if (addr == `OSC_STAT_OFS) begin
      return OSC_REG_STAT;
    end else begin
      return OSC_REG_NONE;
    end
  endfunction

  osc_trim_store osc_trim_store_i (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(trim_load),
    .factory_val(r_r.trim_s1),
    .wr(trim_wr),
    .wr_val(r_r.wdata),
    .trim(trim_q),
    .user_trim(user_trim_q)
  );

  always_comb begin
    logic [7:0] newc;
    logic xedge;
    newc = r_r.ctrl;
    xedge = r_r.xsync[1] & ~r_r.xsync[2];
    r_nxt = r_r;
    trim_load = 1'b0;
    trim_wr = 1'b0;

    // Pin inputs pass two flops before use
    r_nxt.xsync = {r_r.xsync[1:0], xtal_clk_pin};
    r_nxt.off_s = {r_r.off_s[0], crystal_off_option};
    r_nxt.trim_s0 = factory_trim;
    r_nxt.trim_s1 = r_r.trim_s0;

    // Strap and factory trim caught after reset release, once synchronised
    case (r_r.init)
      OSC_INIT_SYNC: begin
        r_nxt.init = OSC_INIT_WAIT;
      end
      OSC_INIT_WAIT: begin
        r_nxt.init = OSC_INIT_LOAD;
      end
      OSC_INIT_LOAD: begin
        r_nxt.ctrl[`OSC_CRYSTAL_ENABLE_BIT_BIT] = ~r_r.off_s[1];
        trim_load = 1'b1;
        r_nxt.init = OSC_INIT_RUN;
      end
      default: begin
      end
    endcase

    // Stability count only advisory; software owns the wait
    if (!r_r.ctrl[`OSC_CRYSTAL_ENABLE_BIT_BIT]) begin
      r_nxt.xcnt = 10'h000;
      r_nxt.xstable = 1'b0;
    end else if (xedge && !r_r.xstable) begin
      r_nxt.xcnt = r_r.xcnt + 10'd1;
      if (r_r.xcnt == `OSC_XTAL_STABLE_CYC - 10'd1) begin
        r_nxt.xstable = 1'b1;
      end
    end

    // Address and data may arrive in either order
    if (s_axi_awvalid && r_r.awready) begin
      r_nxt.aw_held = 1'b1;
      r_nxt.aw_addr = s_axi_awaddr;
      r_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && r_r.wready) begin
      r_nxt.w_held = 1'b1;
      r_nxt.wdata = s_axi_wdata[7:0];
      r_nxt.wstb = s_axi_wstrb[0];
      r_nxt.wready = 1'b0;
    end
    if (r_r.aw_held && r_r.w_held && !r_r.bvalid) begin
      r_nxt.aw_held = 1'b0;
      r_nxt.w_held = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = `OSC_RESP_OKAY;
      case (osc_decode(r_r.aw_addr))
        OSC_REG_CTRL: begin
          if (r_r.lock == OSC_OPEN && r_r.init == OSC_INIT_RUN && r_r.wstb) begin
            newc = r_r.wdata;
            // Cannot pull the crystal from under the system clock
            if (r_r.ctrl[`OSC_SCK_MSB:`OSC_SCK_LSB] == `OSC_SCK_XTAL) begin
              newc[`OSC_CRYSTAL_ENABLE_BIT_BIT] = r_r.ctrl[`OSC_CRYSTAL_ENABLE_BIT_BIT];
            end
            r_nxt.ctrl = newc;
            r_nxt.lock = OSC_LOCKED;
          end
        end
        OSC_REG_UNLOCK: begin
          if (r_r.wstb) begin
            if (r_r.lock == OSC_LOCKED && r_r.wdata == `OSC_UNLOCK_KEY1) begin
              r_nxt.lock = OSC_KEY1_SEEN;
            end else if (r_r.lock == OSC_KEY1_SEEN && r_r.wdata == `OSC_UNLOCK_KEY2) begin
              r_nxt.lock = OSC_OPEN;
            end else if (r_r.lock != OSC_OPEN) begin
              r_nxt.lock = OSC_LOCKED;
            end
          end
        end
        OSC_REG_TRIM: begin
          trim_wr = r_r.wstb && r_r.init == OSC_INIT_RUN;
        end
        OSC_REG_STAT: begin
        end
        default: begin
          r_nxt.bresp = `OSC_RESP_SLVERR;
        end
      endcase
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
      r_nxt.awready = 1'b1;
      r_nxt.wready = 1'b1;
    end

    // Read path: one read in flight
    if (s_axi_arvalid && r_r.arready) begin
      r_nxt.arready = 1'b0;
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata = 32'h0000_0000;
      r_nxt.rresp = `OSC_RESP_OKAY;
      case (osc_decode(s_axi_araddr))
        OSC_REG_CTRL: begin
          r_nxt.rdata[7:0] = r_r.ctrl;
        end
        OSC_REG_UNLOCK: begin
        end
        OSC_REG_TRIM: begin
          r_nxt.rdata[7:0] = trim_q;
        end
        OSC_REG_STAT: begin
          r_nxt.rdata[`OSC_STAT_READY_BIT] = r_r.init == OSC_INIT_RUN;
          r_nxt.rdata[`OSC_STAT_OPEN_BIT] = r_r.lock == OSC_OPEN;
          r_nxt.rdata[`OSC_STAT_USER_TRIM_BIT] = user_trim_q;
          r_nxt.rdata[`OSC_STAT_XSTABLE_BIT] = r_r.xstable;
        end
        default: begin
          r_nxt.rresp = `OSC_RESP_SLVERR;
        end
      endcase
    end
    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
      r_nxt.arready = 1'b1;
    end

    // Kept as a flop so the output needs no decode
    r_nxt.ipo_fast = r_nxt.ctrl[`OSC_SCK_MSB:`OSC_SCK_LSB] != `OSC_SCK_IPO_SLOW;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= RST_STATE;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign s_axi_awready = r_r.awready;
  assign s_axi_wready = r_r.wready;
  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_bresp = r_r.bresp;
  assign s_axi_arready = r_r.arready;
  assign s_axi_rvalid = r_r.rvalid;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;
  assign crystal_enable_bit = r_r.ctrl[`OSC_CRYSTAL_ENABLE_BIT_BIT];
  assign crystal_pin_override = r_r.ctrl[`OSC_CRYSTAL_ENABLE_BIT_BIT];
  assign internal_osc_enable_bit = r_r.ctrl[`OSC_INTERNAL_OSC_ENABLE_BIT_BIT];
  assign fast_slow_select = r_r.ipo_fast;
  assign ipo_trim = trim_q;
  assign system_clock_source_select = r_r.ctrl[`OSC_SCK_MSB:`OSC_SCK_LSB];
  assign ctrl_misc = r_r.ctrl[7:3];

endmodule
`default_nettype wire

// [shared/osc_regs.svh]
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH

// Register byte offsets on the AXI4-Lite port
`define OSC_CTRL_OFS 8'h00
`define OSC_UNLOCK_OFS 8'h04
`define OSC_TRIM_OFS 8'h08
`define OSC_STAT_OFS 8'h0c

// Control register fields and reset value
`define OSC_CTRL_RST 8'ha0
`define OSC_INTERNAL_OSC_ENABLE_BIT_BIT 7
`define OSC_CRYSTAL_ENABLE_BIT_BIT 6
`define OSC_SCK_MSB 2
`define OSC_SCK_LSB 0

// System clock source codes
`define OSC_SCK_IPO_FAST 3'h0
`define OSC_SCK_IPO_SLOW 3'h1
`define OSC_SCK_XTAL 3'h2

// Unlock key pair
`define OSC_UNLOCK_KEY1 8'he7
`define OSC_UNLOCK_KEY2 8'h18

// Status register bit positions
`define OSC_STAT_READY_BIT 0
`define OSC_STAT_OPEN_BIT 1
`define OSC_STAT_USER_TRIM_BIT 2
`define OSC_STAT_XSTABLE_BIT 3

// Trim reset value before the factory load
`define OSC_TRIM_RST 8'h00

// Crystal cycles counted before the crystal is reported stable
`define OSC_XTAL_STABLE_CYC 10'd1000

// AXI responses
`define OSC_RESP_OKAY 2'h0
`define OSC_RESP_SLVERR 2'h2

`endif

// [shared/osc_pkg.sv]
package osc_pkg;

  typedef enum logic [1:0] {
    OSC_INIT_SYNC,
    OSC_INIT_WAIT,
    OSC_INIT_LOAD,
    OSC_INIT_RUN
  } osc_init_t;

  typedef enum logic [1:0] {
    OSC_LOCKED,
    OSC_KEY1_SEEN,
    OSC_OPEN
  } osc_lock_t;

  typedef enum logic [2:0] {
    OSC_REG_CTRL,
    OSC_REG_UNLOCK,
    OSC_REG_TRIM,
    OSC_REG_STAT,
    OSC_REG_NONE
  } osc_reg_t;

  typedef struct packed {
    logic [7:0] trim;
    logic user;
  } osc_trim_state_t;

  typedef struct packed {
    osc_init_t init;
    osc_lock_t lock;
    logic [7:0] ctrl;
    logic ipo_fast;
    logic [1:0] off_s;
    logic [7:0] trim_s0;
    logic [7:0] trim_s1;
    logic [2:0] xsync;
    logic [9:0] xcnt;
    logic xstable;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] wdata;
    logic wstb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } osc_state_t;

endpackage

// [design/osc_trim_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "osc_regs.svh"

module osc_trim_store
  import osc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Factory load
  input wire logic load,
  input wire logic [7:0] factory_val,
  // User override
  input wire logic wr,
  input wire logic [7:0] wr_val,
  // Trim out
  output logic [7:0] trim,
  output logic user_trim
);

  osc_trim_state_t r_r;
  osc_trim_state_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (load) begin
      r_nxt.trim = factory_val;
      r_nxt.user = 1'b0;
    end else if (wr) begin
      r_nxt.trim = wr_val;
      r_nxt.user = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '{trim: `OSC_TRIM_RST, user: 1'b0};
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign trim = r_r.trim;
  assign user_trim = r_r.user;

endmodule
`default_nettype wire

// [dv/osc_source_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module osc_source_ctrl_monitor
  import osc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Oscillator side
  input wire logic crystal_off_option,
  input wire logic [7:0] factory_trim,
  input wire logic crystal_enable_bit,
  input wire logic crystal_pin_override,
  input wire logic internal_osc_enable_bit,
  input wire logic fast_slow_select,
  input wire logic [7:0] ipo_trim,
  input wire logic [2:0] system_clock_source_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  property p_wr;
    s_wr_taken |=> s_wr_answer;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_pin;
    crystal_pin_override == crystal_enable_bit;
  endproperty
  a_pin: assert property (p_pin) else $error("pin override differs");
  property p_fast;
    fast_slow_select == (system_clock_source_select != 3'h1);
  endproperty
  a_fast: assert property (p_fast) else $error("speed select wrong");
  property p_xoff;
    $fell(crystal_enable_bit) |-> $past(system_clock_source_select) != 3'h2;
  endproperty
  a_xoff: assert property (p_xoff) else $error("crystal stopped in use");
  // Oscillator enable and clock select move only with a completed write
  property p_ctl;
    $changed({internal_osc_enable_bit, system_clock_source_select}) |-> $rose(s_axi_bvalid);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control moved alone");
  property p_init;
    // Start-up load needs three enabled edges after release
    ($fell(rst) && ce) ##1 ce [*2] |=>
      (crystal_enable_bit == !crystal_off_option && ipo_trim == factory_trim);
  endproperty
  a_init: assert property (p_init) else $error("reset load wrong");
endmodule
bind osc_source_ctrl osc_source_ctrl_monitor osc_source_ctrl_monitor_i (.*);
`default_nettype wire

// [dv/osc_source_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "osc_regs.svh"
module osc_source_ctrl_bench
  import osc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, xtal_clk_pin = 1'b0, crystal_off_option = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, factory_trim = 8'h5a;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic crystal_enable_bit, crystal_pin_override, internal_osc_enable_bit, fast_slow_select;
  logic [7:0] ipo_trim;
  logic [2:0] system_clock_source_select;
  logic [4:0] ctrl_misc;
  int n_errors = 0, checks = 0;

  always #2.5 clk = ~clk;
  // Crystal only swings while enabled
  always #7.3 xtal_clk_pin = crystal_enable_bit ? ~xtal_clk_pin : 1'b0;

  osc_source_ctrl osc_source_ctrl_i (.*);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo(input bit hit);
    if (hit) begin
      n_errors++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw, w, v, b;
    logic [1:0] r;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      v = s_axi_bvalid;
      b = v && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      s_axi_bready <= v && !b;
      n++;
    end while (!b && n < 200);
    tmo(!b);
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic ar, v, h;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      h = v && s_axi_rready;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      s_axi_rready <= v && !h;
      n++;
    end while (!h && n < 200);
    tmo(!h);
  endtask

  task automatic poll(input int k);
    int n;
    n = 0;
    do begin
      rd(`OSC_STAT_OFS);
      n++;
    end while (rv[k] !== 1'b1 && n < 2000);
    tmo(rv[k] !== 1'b1);
  endtask

  task automatic unlock_wr(input logic [7:0] d);
    wr(`OSC_UNLOCK_OFS, `OSC_UNLOCK_KEY1, `OSC_RESP_OKAY);
    wr(`OSC_UNLOCK_OFS, `OSC_UNLOCK_KEY2, `OSC_RESP_OKAY);
    wr(`OSC_CTRL_OFS, d, `OSC_RESP_OKAY);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    poll(`OSC_STAT_READY_BIT);
    @(negedge clk);
  endtask

  initial begin
    do_reset();
    chk("xtal", 32'h1, 32'(crystal_enable_bit));
    chk("trim", 32'(factory_trim), 32'(ipo_trim));
    wr(`OSC_CTRL_OFS, 8'h01, `OSC_RESP_OKAY);
    rd(`OSC_CTRL_OFS);
    chk("ctrl", 32'(`OSC_CTRL_RST | 8'h40), rv);
    poll(`OSC_STAT_XSTABLE_BIT);
    for (int i = 0; i < 3; i++) begin
      unlock_wr(8'hc0 | 8'(i));
      @(negedge clk);
      chk("sel", i, 32'(system_clock_source_select));
      chk("fast", 32'(i != 1), 32'(fast_slow_select));
      chk("misc", 32'h18, 32'(ctrl_misc));
    end
    wr(`OSC_CTRL_OFS, 8'hc1, `OSC_RESP_OKAY);
    rd(`OSC_CTRL_OFS);
    chk("ctrl", 32'hc2, rv);
    // Broken key pair must leave the register locked
    wr(`OSC_UNLOCK_OFS, `OSC_UNLOCK_KEY1, `OSC_RESP_OKAY);
    wr(`OSC_UNLOCK_OFS, 8'h00, `OSC_RESP_OKAY);
    wr(`OSC_UNLOCK_OFS, `OSC_UNLOCK_KEY2, `OSC_RESP_OKAY);
    wr(`OSC_CTRL_OFS, 8'hc1, `OSC_RESP_OKAY);
    rd(`OSC_CTRL_OFS);
    chk("ctrl_locked", 32'hc2, rv);
    unlock_wr(8'h80);
    @(negedge clk);
    chk("xtal", 32'h1, 32'(crystal_enable_bit));
    unlock_wr(8'h00);
    @(negedge clk);
    chk("xtal", 32'h0, 32'(crystal_enable_bit));
    chk("pin", 32'h0, 32'(crystal_pin_override));
    chk("int_osc", 32'h0, 32'(internal_osc_enable_bit));
    chk("misc", 32'h0, 32'(ctrl_misc));
    wr(`OSC_TRIM_OFS, 8'h33, `OSC_RESP_OKAY);
    @(negedge clk);
    chk("trim", 32'h33, 32'(ipo_trim));
    // Byte lane zero off: the trim write is dropped
    @(posedge clk);
    s_axi_wstrb <= 4'h0;
    wr(`OSC_TRIM_OFS, 8'h77, `OSC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`OSC_TRIM_OFS);
    chk("trim_rd", 32'h33, rv);
    rd(`OSC_STAT_OFS);
    chk("user", 32'h1, 32'(rv[`OSC_STAT_USER_TRIM_BIT]));
    rd(8'h10);
    chk("rresp", 32'(`OSC_RESP_SLVERR), 32'(rr));
    chk("rdata", 32'h0, rv);
    wr(8'h10, 8'h00, `OSC_RESP_SLVERR);
    crystal_off_option <= 1'b1;
    do_reset();
    chk("trim", 32'(factory_trim), 32'(ipo_trim));
    chk("xtal", 32'h0, 32'(crystal_enable_bit));
    rd(`OSC_STAT_OFS);
    chk("user", 32'h0, 32'(rv[`OSC_STAT_USER_TRIM_BIT]));
    // Low clock enable holds the start-up load back
    crystal_off_option <= 1'b0;
    ce <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("frozen_xtal", 32'h0, 32'(crystal_enable_bit));
    chk("frozen_trim", 32'(`OSC_TRIM_RST), 32'(ipo_trim));
    @(posedge clk);
    ce <= 1'b1;
    poll(`OSC_STAT_READY_BIT);
    @(negedge clk);
    chk("xtal_ce", 32'h1, 32'(crystal_enable_bit));
    chk("trim_ce", 32'(factory_trim), 32'(ipo_trim));
    finish_test();
  end
endmodule
`default_nettype wire
